// file: dha_pkg.sv
// Constants, register map and state codes of the DMA handshake engine.
// Assumes a single clock domain and 32-bit AHB-Lite buses.
package dha_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int NCH = 4;
	localparam int CHW = 2;
	localparam int NW = 11;

	// ---------------------------------------------------------------
	// Register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CH_ENABLE = 8'h00;
	localparam logic [7:0] REG_REQ_MASK = 8'h04;
	localparam logic [7:0] REG_BURST_ONLY = 8'h08;
	localparam logic [7:0] REG_CTRL_BASE = 8'h0C;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
	localparam logic [7:0] REG_IRQ_MASK = 8'h14;
	localparam logic [7:0] REG_ENG_STATUS = 8'h18;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [NCH-1:0] RST_CH = 4'h0;
	localparam logic [31:0] RST_WORD = 32'h00000000;

	// ---------------------------------------------------------------
	// Channel control structure in memory
	// ---------------------------------------------------------------
	localparam logic [31:0] CS_SRC_OFS = 32'h00000000;
	localparam logic [31:0] CS_DST_OFS = 32'h00000004;
	localparam logic [31:0] CS_CTRL_OFS = 32'h00000008;
	localparam int CS_STRIDE_LSB = 4;
	localparam int CF_CYC_LSB = 0;
	localparam int CF_N_LSB = 4;
	localparam int CF_N_W = 10;
	localparam int CF_R_LSB = 14;
	localparam int CF_NOPULSE_BIT = 2;
	localparam logic [2:0] CYC_INVALID = 3'h0;

	// ---------------------------------------------------------------
	// Arbitration rate
	// ---------------------------------------------------------------
	localparam logic [3:0] RPOW_MAX = 4'hA;
	localparam logic [NW-1:0] RATE_MAX = 11'h400;
	localparam logic [NW-1:0] RATE_ONE = 11'h001;

	// ---------------------------------------------------------------
	// AHB encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// ---------------------------------------------------------------
	// Engine states
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_RCTL = 4'h1,
		S_RSRC = 4'h2,
		S_RDST = 4'h3,
		S_RDAT = 4'h4,
		S_WDAT = 4'h5,
		S_WCTL = 4'h6,
		S_WAITREQ = 4'h7,
		S_FIN = 4'h8,
		S_GAP = 4'h9
	} dha_state_t;

endpackage

// file: dha_rate.sv
// Arbitration interval and group size from the exponent.
// Assumes the remaining count never exceeds the interval limit width.
`timescale 1ns/1ps
`default_nettype none
module dha_rate
	import dha_pkg::*;
(
	// Exponent and mode
	input wire logic [3:0] rpow,
	input wire logic single,
	// Count
	input wire logic [NW-1:0] n_left,
	output logic [NW-1:0] rate,
	output logic [NW-1:0] grp
);

	// ---------------------------------------------------------------
	// Interval and group
	// ---------------------------------------------------------------
	always_comb begin
		if (rpow >= RPOW_MAX) begin
			rate = RATE_MAX; // (RQ12)
		end else begin
			rate = RATE_ONE << rpow; // (RQ12)
		end
		if (single) begin
			grp = RATE_ONE; // (RQ10)
		end else if (n_left < rate) begin
			grp = n_left; // (RQ13)
		end else begin
			grp = rate; // (RQ13)
		end
	end

endmodule
`default_nettype wire

// file: dha_req_qual.sv
// Per-channel request qualification.
// Assumes request inputs synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module dha_req_qual
	import dha_pkg::*;
(
	// Configuration
	input wire logic [NCH-1:0] enable,
	input wire logic [NCH-1:0] req_mask,
	input wire logic [NCH-1:0] burst_only,
	// Peripheral requests
	input wire logic [NCH-1:0] burst_req,
	input wire logic [NCH-1:0] single_req,
	// Qualified
	output logic [NCH-1:0] want,
	output logic [NCH-1:0] want_single
);

	// ---------------------------------------------------------------
	// Per channel
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			logic live;
			logic sgl;
			assign live = enable[gi] & ~req_mask[gi]; // (RQ17)
			assign sgl = single_req[gi] & ~burst_only[gi] & ~burst_req[gi]; // (RQ6) (RQ11)
			assign want[gi] = live & (burst_req[gi] | sgl);
			assign want_single[gi] = live & sgl;
		end
	endgenerate

endmodule
`default_nettype wire

// file: dha_top.sv
// DMA handshake and arbitration-rate engine with register slave and memory master.
// Assumes one clock, single-word AHB-Lite transfers and OKAY memory responses.
//
// Operation
// (RQ1) One-cycle done pulse at cycle end when control bit 2 is zero.
// (RQ2) Only the finishing channel's done is high during the pulse.
// (RQ3) No done pulse while stall was high the previous clock.
// (RQ4) With wait-on-request, busy and done wait until burst request drops.
// (RQ5) Peripheral keeps wait-on-request steady from request until busy falls.
// (RQ6) Burst request beats a simultaneous single request.
// (RQ7) Service order: control, source end, destination end, data, control write.
// (RQ8) End pointers are fetched again before each further data item.
// (RQ9) Burst-only flag cleared at service end when remaining is below 2^R.
// (RQ10) Single-request service moves exactly one item.
// (RQ11) Single requests accepted only while burst-only flag is zero.
// (RQ12) Four-bit exponent: 1 to 512 transfers, codes 10-15 give 1024.
// (RQ13) Full groups of 2^R, leftover group last.
// (RQ14) Exponent comes from the control word in memory.
// (RQ15) Software avoids large exponents on low-priority channels.
// (RQ16) Busy stays low at least one clock between services.
// (RQ17) Masked channels ignore both request inputs.
// (RQ18) Transfers counted against 2^R and remaining count, then re-arbitrate.
`timescale 1ns/1ps
`default_nettype none
module dha_top
	import dha_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Register slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Memory master
	output logic [31:0] m_haddr,
	output logic [1:0] m_htrans,
	output logic m_hwrite,
	output logic [2:0] m_hsize,
	output logic [31:0] m_hwdata,
	input wire logic [31:0] m_hrdata,
	input wire logic m_hready,
	// Peripheral handshake
	input wire logic [NCH-1:0] burst_req,
	input wire logic [NCH-1:0] single_req,
	input wire logic [NCH-1:0] wait_on_req,
	input wire logic stall,
	output logic [NCH-1:0] busy,
	output logic [NCH-1:0] cycle_done,
	// Interrupt
	output logic irq
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	dha_state_t state;
	dha_state_t next_state;
	logic [NCH-1:0] ch_enable;
	logic [NCH-1:0] req_mask;
	logic [NCH-1:0] burst_only;
	logic [31:0] ctrl_base;
	logic [NCH-1:0] irq_status;
	logic [NCH-1:0] irq_mask;
	logic [NCH-1:0] want;
	logic [NCH-1:0] want_single;
	logic [CHW-1:0] cur_ch;
	logic [CHW-1:0] pick_ch;
	logic pick_any;
	logic cur_single;
	logic [31:0] ctrl_word;
	logic [31:0] src_end;
	logic [31:0] dst_end;
	logic [31:0] data_buf;
	logic [NW-1:0] n_left;
	logic [NW-1:0] grp_left;
	logic [NW-1:0] rate;
	logic [NW-1:0] grp;
	logic dph;
	logic is_acc;
	logic acc_done;
	logic stall_prev;
	logic done_fire;
	logic [NCH-1:0] done_evt;
	logic [31:0] ch_base;
	logic [31:0] item_ofs;
	logic [31:0] ctrl_new;
	logic s_take;
	logic s_wr;
	logic [7:0] s_addr;
	logic [31:0] rd_mux;

	// ---------------------------------------------------------------
	// Request qualification and rate
	// ---------------------------------------------------------------
	dha_req_qual u_qual (
		.enable(ch_enable),
		.req_mask(req_mask),
		.burst_only(burst_only),
		.burst_req(burst_req),
		.single_req(single_req),
		.want(want),
		.want_single(want_single)
	);

	dha_rate u_rate (
		.rpow(m_hrdata[CF_R_LSB +: 4]), // (RQ14)
		.single(cur_single),
		.n_left(NW'({1'b0, m_hrdata[CF_N_LSB +: CF_N_W]}) + RATE_ONE),
		.rate(rate),
		.grp(grp)
	);

	// ---------------------------------------------------------------
	// Arbitration pick, lowest channel first
	// ---------------------------------------------------------------
	always_comb begin
		pick_any = 1'b0;
		pick_ch = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (want[i]) begin
				pick_any = 1'b1;
				pick_ch = CHW'(i);
			end
		end
	end

	// ---------------------------------------------------------------
	// Memory master
	// ---------------------------------------------------------------
	assign is_acc = (state == S_RCTL) || (state == S_RSRC) || (state == S_RDST) ||
		(state == S_RDAT) || (state == S_WDAT) || (state == S_WCTL);
	assign acc_done = is_acc && dph && m_hready;
	assign m_htrans = (is_acc && !dph) ? HTRANS_NONSEQ : HTRANS_IDLE;
	assign m_hwrite = (state == S_WDAT) || (state == S_WCTL);
	assign m_hsize = HSIZE_WORD;
	assign ch_base = ctrl_base + {{(32 - CHW - CS_STRIDE_LSB){1'b0}}, cur_ch, {CS_STRIDE_LSB{1'b0}}};
	assign item_ofs = {{(30 - NW){1'b0}}, n_left - RATE_ONE, 2'b00};

	always_comb begin
		unique case (state)
			S_RSRC: m_haddr = ch_base + CS_SRC_OFS;
			S_RDST: m_haddr = ch_base + CS_DST_OFS;
			S_RDAT: m_haddr = src_end - item_ofs;
			S_WDAT: m_haddr = dst_end - item_ofs;
			default: m_haddr = ch_base + CS_CTRL_OFS;
		endcase
	end

	always_comb begin
		ctrl_new = ctrl_word;
		ctrl_new[CF_N_LSB +: CF_N_W] = (n_left == '0) ? '0 : CF_N_W'(n_left - RATE_ONE);
		if (n_left == '0) begin
			ctrl_new[CF_CYC_LSB +: 3] = CYC_INVALID;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			dph <= 1'b0;
		end else if (is_acc && !dph && m_hready) begin
			dph <= 1'b1;
		end else if (acc_done) begin
			dph <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			m_hwdata <= RST_WORD;
		end else if (is_acc && !dph && m_hready) begin
			m_hwdata <= (state == S_WCTL) ? ctrl_new : data_buf;
		end
	end

	// ---------------------------------------------------------------
	// Service sequence
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			S_IDLE: if (pick_any) next_state = S_RCTL;
			S_RCTL: if (acc_done) next_state = S_RSRC; // (RQ7)
			S_RSRC: if (acc_done) next_state = S_RDST; // (RQ7)
			S_RDST: if (acc_done) next_state = S_RDAT; // (RQ7)
			S_RDAT: if (acc_done) next_state = S_WDAT;
			S_WDAT: begin
				if (acc_done) begin
					next_state = (grp_left == RATE_ONE) ? S_WCTL : S_RSRC; // (RQ8) (RQ18)
				end
			end
			S_WCTL: begin
				if (acc_done) begin
					next_state = (wait_on_req[cur_ch] && burst_req[cur_ch]) ? S_WAITREQ : S_FIN; // (RQ4)
				end
			end
			S_WAITREQ: if (!burst_req[cur_ch]) next_state = S_FIN; // (RQ4) (RQ5)
			S_FIN: if (!done_fire || !stall_prev) next_state = S_GAP; // (RQ3)
			S_GAP: next_state = S_IDLE; // (RQ16)
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_ch <= '0;
			cur_single <= 1'b0;
		end else if (state == S_IDLE && pick_any) begin
			cur_ch <= pick_ch;
			cur_single <= want_single[pick_ch]; // (RQ6) (RQ10)
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_word <= RST_WORD;
			src_end <= RST_WORD;
			dst_end <= RST_WORD;
			data_buf <= RST_WORD;
		end else if (acc_done) begin
			if (state == S_RCTL) ctrl_word <= m_hrdata;
			if (state == S_RSRC) src_end <= m_hrdata;
			if (state == S_RDST) dst_end <= m_hrdata;
			if (state == S_RDAT) data_buf <= m_hrdata;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			n_left <= '0;
			grp_left <= '0;
		end else if (acc_done && state == S_RCTL) begin
			n_left <= NW'({1'b0, m_hrdata[CF_N_LSB +: CF_N_W]}) + RATE_ONE;
			grp_left <= grp; // (RQ12) (RQ13) (RQ18)
		end else if (acc_done && state == S_WDAT) begin
			n_left <= n_left - RATE_ONE; // (RQ18)
			grp_left <= grp_left - RATE_ONE; // (RQ18)
		end
	end

	// ---------------------------------------------------------------
	// Busy and done
	// ---------------------------------------------------------------
	assign done_fire = (n_left == '0) && !ctrl_word[CF_NOPULSE_BIT]; // (RQ1)

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			stall_prev <= 1'b0;
		end else begin
			stall_prev <= stall;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy <= RST_CH;
		end else if (state == S_IDLE && pick_any) begin
			busy <= RST_CH | (NCH'(1) << pick_ch);
		end else if (next_state == S_FIN && state != S_FIN) begin
			busy <= RST_CH; // (RQ4) (RQ16)
		end
	end

	always_comb begin
		done_evt = RST_CH;
		if (state == S_FIN && done_fire && !stall_prev) begin
			done_evt[cur_ch] = 1'b1; // (RQ1) (RQ2) (RQ3)
		end
	end
	assign cycle_done = done_evt;

	// ---------------------------------------------------------------
	// Register slave
	// ---------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign s_take = hsel && htrans[1] && hready;

	always_comb begin
		unique case (haddr[7:0])
			REG_CH_ENABLE: rd_mux = {{(32 - NCH){1'b0}}, ch_enable};
			REG_REQ_MASK: rd_mux = {{(32 - NCH){1'b0}}, req_mask};
			REG_BURST_ONLY: rd_mux = {{(32 - NCH){1'b0}}, burst_only};
			REG_CTRL_BASE: rd_mux = ctrl_base;
			REG_IRQ_STATUS: rd_mux = {{(32 - NCH){1'b0}}, irq_status};
			REG_IRQ_MASK: rd_mux = {{(32 - NCH){1'b0}}, irq_mask};
			REG_ENG_STATUS: rd_mux = {{(32 - 4 - CHW - NCH){1'b0}}, busy, cur_ch, state};
			default: rd_mux = RST_WORD;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_wr <= 1'b0;
			s_addr <= '0;
			hrdata <= RST_WORD;
		end else begin
			s_wr <= s_take && hwrite;
			if (s_take) begin
				s_addr <= haddr[7:0];
			end
			if (s_take && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ch_enable <= RST_CH;
			req_mask <= RST_CH;
			ctrl_base <= RST_WORD;
			irq_mask <= RST_CH;
		end else if (s_wr) begin
			if (s_addr == REG_CH_ENABLE) ch_enable <= hwdata[NCH-1:0];
			if (s_addr == REG_REQ_MASK) req_mask <= hwdata[NCH-1:0];
			if (s_addr == REG_CTRL_BASE) ctrl_base <= hwdata;
			if (s_addr == REG_IRQ_MASK) irq_mask <= hwdata[NCH-1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			burst_only <= RST_CH;
		end else begin
			if (s_wr && s_addr == REG_BURST_ONLY) begin
				burst_only <= hwdata[NCH-1:0];
			end
			if (next_state == S_FIN && state != S_FIN && n_left < rate_q(ctrl_word)) begin
				burst_only[cur_ch] <= 1'b0; // (RQ9)
			end
		end
	end

	function automatic logic [NW-1:0] rate_q(input logic [31:0] cw);
		logic [3:0] r;
		r = cw[CF_R_LSB +: 4];
		rate_q = (r >= RPOW_MAX) ? RATE_MAX : (RATE_ONE << r);
	endfunction

	// ---------------------------------------------------------------
	// Interrupt
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_status <= RST_CH;
		end else if (s_wr && s_addr == REG_IRQ_STATUS) begin
			irq_status <= (irq_status & ~hwdata[NCH-1:0]) | done_evt;
		end else begin
			irq_status <= irq_status | done_evt;
		end
	end

	assign irq = |(irq_status & irq_mask);

endmodule
`default_nettype wire

// file: dha_mem.sv
// Behavioural AHB-Lite memory facing the engine's master port.
// Assumes single word transfers, OKAY responses and one clock.
`timescale 1ns/1ps
`default_nettype none
module dha_mem
	import dha_pkg::*;
(
	// Clock and mode
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic slow,
	// Memory slave
	input wire logic [31:0] m_haddr,
	input wire logic [1:0] m_htrans,
	input wire logic m_hwrite,
	input wire logic [31:0] m_hwdata,
	output logic [31:0] m_hrdata,
	output logic m_hready
);
	logic [31:0] mem [256];
	logic [8:0] tr [1024];
	int ntr;
	logic dph, dwr, tick;
	logic [7:0] didx;
	logic [31:0] junk;
	// Wait states every other cycle in slow mode
	assign m_hready = !slow || tick;
	// Outside a read data phase the bus shows a moving pattern
	assign m_hrdata = (dph && !dwr) ? mem[didx] : junk;
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			dph <= 1'b0;
			dwr <= 1'b0;
			tick <= 1'b0;
			didx <= 8'h00;
			ntr <= 0;
			junk <= 32'h5A3C_9612;
		end else begin
			tick <= !tick;
			junk <= junk + 32'h0101_0101;
			if (m_hready) begin
				if (dph && dwr) mem[didx] <= m_hwdata;
				dph <= m_htrans[1];
				dwr <= m_hwrite;
				didx <= m_haddr[9:2];
				if (m_htrans[1]) begin
					tr[ntr] <= {m_hwrite, m_haddr[9:2]};
					ntr <= ntr + 1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: dha_sva.sv
// Handshake and memory-master checker for the DMA engine.
// Assumes it is bound to the engine's top module.
`timescale 1ns/1ps
`default_nettype none
module dha_sva
	import dha_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [31:0] m_haddr,
	input wire logic [1:0] m_htrans,
	input wire logic m_hwrite,
	input wire logic m_hready,
	input wire logic [NCH-1:0] burst_req,
	input wire logic [NCH-1:0] wait_on_req,
	input wire logic stall,
	input wire logic [NCH-1:0] busy,
	input wire logic [NCH-1:0] cycle_done
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	sequence s_pulse; |cycle_done; endsequence
	sequence s_start; $rose(|busy); endsequence
	sequence s_end; $fell(|busy); endsequence
	property p_done_one; s_pulse |=> !(|cycle_done); endproperty
	property p_done_idle; s_pulse |-> busy == '0; endproperty
	property p_done_hot; $onehot0(cycle_done); endproperty
	property p_stall; $past(stall) |-> cycle_done == '0; endproperty
	property p_wait; |(busy & wait_on_req & burst_req) |=> busy == $past(busy); endproperty
	property p_gap; s_end |=> busy == '0; endproperty
	property p_first; s_start |-> m_htrans == HTRANS_NONSEQ && !m_hwrite && m_haddr[3:0] == CS_CTRL_OFS[3:0];
	endproperty
	property p_hold; m_htrans[1] && !m_hready |=> $stable(m_haddr) && m_htrans == HTRANS_NONSEQ; endproperty
	a_done_one: assert property (p_done_one)
		else $error("done pulse longer than one cycle");
	a_done_idle: assert property (p_done_idle)
		else $error("done pulse while busy");
	a_done_hot: assert property (p_done_hot)
		else $error("two done pulses at once");
	a_stall: assert property (p_stall)
		else $error("done pulse after stall");
	a_wait: assert property (p_wait)
		else $error("busy fell while request held");
	a_gap: assert property (p_gap)
		else $error("busy low for under a cycle");
	a_first: assert property (p_first)
		else $error("service does not open with control read");
	a_hold: assert property (p_hold)
		else $error("address phase dropped before ready");
endmodule
bind dha_top dha_sva i_dha_sva (.sys_clk(sys_clk), .arst_n(arst_n), .m_haddr(m_haddr), .m_htrans(m_htrans),
	.m_hwrite(m_hwrite), .m_hready(m_hready), .burst_req(burst_req), .wait_on_req(wait_on_req),
	.stall(stall), .busy(busy), .cycle_done(cycle_done));
`default_nettype wire

// file: tb.sv
// Self-checking bench for the DMA handshake engine.
// Assumes the memory model and checker files compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb
	import dha_pkg::*;
;
	logic sys_clk = 0, arst_n = 0, hsel = 0, hwrite = 0, stall = 0, slow = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, m_haddr, m_hwdata, m_hrdata, rv;
	logic [1:0] htrans = HTRANS_IDLE, m_htrans;
	logic [2:0] m_hsize;
	logic hreadyout, hresp, m_hwrite, m_hready, irq;
	logic [NCH-1:0] burst_req = 0, single_req = 0, wait_on_req = 0, busy, cycle_done;
	int miscompares = 0, n_compared = 0, t0, dn;
	int ndone [NCH];
	logic [8:0] exp_tr [10] = '{9'h042, 9'h040, 9'h041, 9'h080, 9'h1C0, 9'h040, 9'h041, 9'h081, 9'h1C1, 9'h142};
	always #2.5 sys_clk = !sys_clk;
	always @(posedge sys_clk) for (int i = 0; i < NCH; i++) if (cycle_done[i] === 1'b1) ndone[i] <= ndone[i] + 1;
	dha_top i_dha_top (.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .m_haddr(m_haddr), .m_htrans(m_htrans), .m_hwrite(m_hwrite),
		.m_hsize(m_hsize), .m_hwdata(m_hwdata), .m_hrdata(m_hrdata), .m_hready(m_hready),
		.burst_req(burst_req), .single_req(single_req), .wait_on_req(wait_on_req), .stall(stall),
		.busy(busy), .cycle_done(cycle_done), .irq(irq));
	dha_mem i_dha_mem (.sys_clk(sys_clk), .arst_n(arst_n), .slow(slow), .m_haddr(m_haddr), .m_htrans(m_htrans),
		.m_hwrite(m_hwrite), .m_hwdata(m_hwdata), .m_hrdata(m_hrdata), .m_hready(m_hready));
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task conclude;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task ahw;
		int k;
		for (k = 0; k < 100; k++) begin
			@(posedge sys_clk);
			if (hreadyout === 1'b1) break;
		end
		if (k == 100) begin
			miscompares++;
			conclude;
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		ahw;
		htrans <= HTRANS_IDLE;
		hsel <= 1'b0;
		hwdata <= d;
		ahw;
		rv = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rv, e);
	endtask
	task wb(input int ch, input logic lv);
		int k;
		for (k = 0; k < 5000 && busy[ch] !== lv; k++) @(posedge sys_clk);
		if (k == 5000) begin
			miscompares++;
			conclude;
		end
	endtask
	task wd(input int ch);
		int k;
		for (k = 0; k < 5000 && cycle_done[ch] !== 1'b1; k++) @(posedge sys_clk);
		if (k == 5000) begin
			miscompares++;
			conclude;
		end
	endtask
	task cfg(input int ch, input int n, input int r);
		i_dha_mem.mem[64 + ch * 4] = 32'(512 + ch * 64 + (n - 1) * 4);
		i_dha_mem.mem[65 + ch * 4] = 32'(768 + ch * 64 + (n - 1) * 4);
		i_dha_mem.mem[66 + ch * 4] = 32'(((n - 1) << 4) | (r << 14) | 1);
		for (int i = 0; i < 16; i++) begin
			i_dha_mem.mem[128 + ch * 16 + i] = 32'hA500_0000 + 32'(ch * 16 + i);
			i_dha_mem.mem[192 + ch * 16 + i] = 32'h0;
		end
	endtask
	task cmpd(input int ch, input int n);
		for (int i = 0; i <= n; i++) chk(i_dha_mem.mem[192 + ch * 16 + i], (i < n) ? 32'hA500_0000 + 32'(ch * 16 + i) : 0);
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task t_regs;
		for (int a = 0; a < 32; a += 4) rd(8'(a), 32'h0);
		wr(REG_CTRL_BASE, 32'h100);
		wr(REG_CH_ENABLE, 32'hF);
		wr(REG_IRQ_MASK, 32'hF);
		chk(32'(hresp), 32'h0);
		chk(32'(m_hsize), 32'(HSIZE_WORD));
		$display("registers done");
	endtask
	task t_rate;
		int r_tab [5] = '{0, 1, 2, 3, 15};
		int n_srv [5] = '{5, 3, 2, 1, 1};
		int nc;
		for (int j = 0; j < 5; j++) begin
			cfg(0, 5, r_tab[j]);
			wr(REG_BURST_ONLY, 32'h1);
			slow <= (j == 3);
			t0 = i_dha_mem.ntr;
			burst_req[0] <= 1'b1;
			wd(0);
			burst_req[0] <= 1'b0;
			nc = 0;
			for (int i = t0; i < i_dha_mem.ntr; i++) nc += (i_dha_mem.tr[i] == 9'h042);
			chk(32'(nc), 32'(n_srv[j]));
			if (j == 1) for (int i = 0; i < 10; i++) chk(32'(i_dha_mem.tr[t0 + i]), 32'(exp_tr[i]));
			cmpd(0, 5);
			rd(REG_BURST_ONLY, 32'h0);
		end
		tick(1);
		chk(32'(irq), 32'h1);
		wr(REG_IRQ_MASK, 32'h0);
		tick(1);
		chk(32'(irq), 32'h0);
		wr(REG_IRQ_MASK, 32'hF);
		rd(REG_IRQ_STATUS, 32'h1);
		wr(REG_IRQ_STATUS, 32'h1);
		tick(1);
		chk(32'(irq), 32'h0);
		$display("rate done");
	endtask
	task t_single;
		cfg(1, 2, 3);
		wr(REG_BURST_ONLY, 32'h2);
		t0 = i_dha_mem.ntr;
		single_req[1] <= 1'b1;
		tick(40);
		chk(32'(i_dha_mem.ntr - t0), 32'h0);
		wr(REG_BURST_ONLY, 32'h0);
		wb(1, 1'b1);
		wb(1, 1'b0);
		chk(32'(i_dha_mem.ntr - t0), 32'd6);
		wd(1);
		single_req[1] <= 1'b0;
		tick(1);
		cfg(1, 2, 1);
		t0 = i_dha_mem.ntr;
		burst_req[1] <= 1'b1;
		single_req[1] <= 1'b1;
		wd(1);
		burst_req[1] <= 1'b0;
		single_req[1] <= 1'b0;
		chk(32'(i_dha_mem.ntr - t0), 32'd10);
		$display("single done");
	endtask
	task t_mask;
		cfg(2, 1, 0);
		wr(REG_REQ_MASK, 32'h4);
		t0 = i_dha_mem.ntr;
		burst_req[2] <= 1'b1;
		single_req[2] <= 1'b1;
		tick(40);
		chk(32'(i_dha_mem.ntr - t0), 32'h0);
		single_req[2] <= 1'b0;
		wr(REG_REQ_MASK, 32'h0);
		wd(2);
		burst_req[2] <= 1'b0;
		cmpd(2, 1);
		tick(1);
		cfg(2, 1, 0);
		i_dha_mem.mem[66 + 2 * 4] = i_dha_mem.mem[66 + 2 * 4] | 32'(1 << CF_NOPULSE_BIT);
		burst_req[2] <= 1'b1;
		wb(2, 1'b1);
		burst_req[2] <= 1'b0;
		wb(2, 1'b0);
		dn = ndone[2];
		tick(10);
		chk(32'(ndone[2]), 32'(dn));
		cmpd(2, 1);
		$display("mask done");
	endtask
	task t_stall;
		cfg(3, 1, 0);
		stall <= 1'b1;
		burst_req[3] <= 1'b1;
		wb(3, 1'b1);
		burst_req[3] <= 1'b0;
		wb(3, 1'b0);
		dn = ndone[3];
		tick(10);
		chk(32'(ndone[3]), 32'(dn));
		stall <= 1'b0;
		wd(3);
		$display("stall done");
	endtask
	task t_wait;
		cfg(0, 1, 0);
		wait_on_req[0] <= 1'b1;
		tick(1);
		t0 = i_dha_mem.ntr;
		burst_req[0] <= 1'b1;
		wb(0, 1'b1);
		tick(40);
		chk(32'(busy[0]), 32'h1);
		chk(32'(i_dha_mem.ntr - t0), 32'd6);
		burst_req[0] <= 1'b0;
		wd(0);
		wait_on_req[0] <= 1'b0;
		cmpd(0, 1);
		$display("wait done");
	endtask
	initial begin
		tick(2);
		arst_n <= 1'b1;
		t_regs;
		t_rate;
		t_single;
		t_mask;
		t_stall;
		t_wait;
		conclude;
	end
endmodule
`default_nettype wire
